// *** bench/ssr_motor_model.sv ***
// Behavioural motor behind the thyristor stage, for the sequencer bench.
// Assumes volt_ref and firing_en come straight from the sequencer.
`timescale 1ns/100ps
module ssr_motor_model (
  input  wire logic [7:0] volt_ref,
  input  wire logic       firing_en,
  input  wire logic [1:0] mode,
  input  wire logic       order_ok,
  output logic      [9:0] load_current_a,
  output logic            phase_rst_ok
);
  // ----------------------------------------
  // Load current: 0 normal, 1 locked, 2 dry
  // ----------------------------------------
  always_comb begin
    if (!firing_en) begin
      load_current_a = 10'h000;  // Stopped motor draws nothing
    end else if (mode == 2'h1) begin
      load_current_a = {2'h0, volt_ref};
    end else if (mode == 2'h2) begin
      load_current_a = 10'h002;
    end else begin
      load_current_a = {5'h00, volt_ref[7:3]};
    end
  end
  // Supply order seen at the terminals
  assign phase_rst_ok = order_ok;
endmodule

// *** bench/test_ssr_ramp_protect.sv ***
// Self-checking bench for the soft-start sequencer.
// Assumes the motor model is compiled first.
`timescale 1ns/100ps
`include "ssr_defines.svh"
module test_ssr_ramp_protect;
  import ssr_pkg::*;
  typedef struct packed {ssr_state_t st; ssr_err_t er; logic [7:0] rf;} ssr_note_t;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clk, rst, start_cmd, stop_cmd, fault_clear, jog_input, chk_on, ord_ok;
  logic       fire, phf, limq, full, ph_ok;
  logic [19:0] pwr;
  logic [9:0] vt [11] = '{`SSR_V0, `SSR_V1, `SSR_V2, `SSR_V3, `SSR_V4, `SSR_V5,
                          `SSR_V6, `SSR_V7, `SSR_V8, `SSR_V9, `SSR_V10};
  logic [7:0] init_v, acc_t, step_v, dec_t, oc_l, oc_t, uc_t, kick, vref;
  logic [8:0] lim;
  logic [3:0] vsel;
  logic [2:0] f4;
  logic [1:0] mode;
  logic [9:0] cur;
  ssr_err_t   err;
  ssr_state_t st, last_st;
  ssr_note_t  notes[$], nt;
  int         err_total, cmp_count, seed, n;

  ssr_ramp_protect #(.TICK_CYCLES(4)) u_ssr_ramp_protect (
    .clk(clk), .rst(rst), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .fault_clear(fault_clear), .jog_input(jog_input), .phase_rst_ok(ph_ok),
    .load_current_a(cur), .initial_voltage_level(init_v), .accel_ramp_time(acc_t),
    .decel_voltage_step(step_v), .decel_ramp_time(dec_t), .start_current_limit(lim),
    .overcurrent_level(oc_l), .overcurrent_time(oc_t), .undercurrent_level(8'h46),
    .undercurrent_time(uc_t), .rated_device_current(3'h0), .rated_line_voltage(vsel),
    .phase_order_check(chk_on), .jog_voltage_level(8'h19), .kick_pulse_time(kick),
    .input_four_function(f4), .volt_ref_q(vref), .firing_en_q(fire), .at_full_q(full),
    .cur_limiting_q(limq), .err_code_q(err), .phase_fault_q(phf),
    .load_power_va_q(pwr), .state_q(st));
  ssr_motor_model u_ssr_motor_model (.volt_ref(vref), .firing_en(fire), .mode(mode),
    .order_ok(ord_ok), .load_current_a(cur), .phase_rst_ok(ph_ok));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic note(input ssr_state_t s, input ssr_err_t e, input logic [7:0] r);
    notes.push_back({s, e, r});
  endtask
  task automatic hit(input int w);
    {start_cmd, stop_cmd, fault_clear} = 3'b100 >> w;
    @(negedge clk);
    {start_cmd, stop_cmd, fault_clear} = 3'b000;
    @(negedge clk);
  endtask
  task automatic wait_st(input ssr_state_t s);
    n = 0;
    while (st !== s && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (st !== s) chk(st, s);
  endtask
  task automatic do_rst();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask
  task automatic run_clear();
    note(ST_IDLE, ERR_NONE, 8'h00);
    hit(2);
    wait_st(ST_IDLE);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Each state change takes the oldest note; ff marks a level not checked
  always @(negedge clk) begin
    if (!rst && st !== last_st) begin
      nt = (notes.size() > 0) ? notes.pop_front() : '1;
      chk(st, nt.st);
      chk(err, nt.er);
      if (nt.rf !== 8'hff) chk(vref, nt.rf);
    end
    last_st <= st;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 92;
    {rst, start_cmd, stop_cmd, fault_clear, jog_input, chk_on, ord_ok} = 7'b1000000;
    init_v = 8'h19 + 8'({$random(seed)} % 66);
    step_v = 8'h28 + 8'({$random(seed)} % 61);
    vsel = 4'({$random(seed)} % 11);
    {acc_t, dec_t, oc_l, oc_t, uc_t, kick} = {8'h01, 8'h00, 8'h78, 24'h0};
    {lim, f4, mode} = 14'h0;
    do_rst();
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_RUN, ERR_NONE, 8'h64);
    hit(0);
    wait_st(ST_RUN);
    chk(32'(n > 380 && n < 420), 1);
    @(negedge clk);
    chk(full, 1);
    chk(pwr, 32'((30'(vt[vsel]) * 30'(cur) * `SSR_SQRT3_Q8) >> 8));
    dec_t = 8'h02;
    note(ST_DECEL, ERR_NONE, step_v);
    note(ST_IDLE, ERR_NONE, 8'h00);
    hit(1);
    wait_st(ST_IDLE);
    chk(32'(n > 760 && n < 820), 1);
    {lim, mode} = {9'h096, 2'h1};
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_FAULT, ERR_RAMP_TIMEOUT, 8'h00);
    hit(0);
    repeat (3) @(negedge clk);
    chk(limq, 1);
    wait_st(ST_FAULT);
    run_clear();
    {kick, oc_t} = {8'h05, 8'h01};
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_RUN, ERR_NONE, 8'h64);
    note(ST_FAULT, ERR_HIGH_CURRENT, 8'h00);
    hit(0);
    wait_st(ST_FAULT);
    run_clear();
    {kick, lim, oc_t, uc_t, mode} = {8'h00, 9'h0, 8'h00, 8'h01, 2'h2};
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_RUN, ERR_NONE, 8'h64);
    note(ST_FAULT, ERR_LOW_CURRENT, 8'h00);
    hit(0);
    wait_st(ST_FAULT);
    run_clear();
    {uc_t, mode, dec_t} = 18'h0;
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_RUN, ERR_NONE, 8'h64);
    note(ST_IDLE, ERR_NONE, 8'h00);
    hit(0);
    wait_st(ST_RUN);
    hit(1);
    wait_st(ST_IDLE);
    {f4, dec_t} = {3'h4, 8'h02};
    note(ST_JOG, ERR_NONE, 8'h19);
    note(ST_JOGDN, ERR_NONE, 8'hff);
    note(ST_IDLE, ERR_NONE, 8'h00);
    jog_input = 1'b1;
    repeat (50) @(negedge clk);
    jog_input = 1'b0;
    wait_st(ST_IDLE);
    note(ST_JOG, ERR_NONE, 8'h19);
    note(ST_FAULT, ERR_RAMP_TIMEOUT, 8'h00);
    jog_input = 1'b1;
    wait_st(ST_FAULT);
    jog_input = 1'b0;
    run_clear();
    {f4, dec_t, chk_on, ord_ok} = 13'h0002;
    do_rst();
    hit(0);
    repeat (2) @(negedge clk);
    chk(phf, 1);
    ord_ok = 1'b1;
    hit(0);
    repeat (2) @(negedge clk);
    chk(st, ST_IDLE);
    chk(phf, 1);
    do_rst();
    note(ST_ACCEL, ERR_NONE, init_v);
    note(ST_IDLE, ERR_NONE, 8'h00);
    hit(0);
    wait_st(ST_ACCEL);
    hit(1);
    wait_st(ST_IDLE);
    chk(notes.size(), 0);
    report_and_stop();
  end
endmodule

// *** rtl/ssr_defines.svh ***
// Constants for the soft-start ramp and protection block.
// Assumes a 125 MHz clock; percent settings are whole percent values.
// Behaviour
// - Ramp voltage over the acceleration time unless current limiting holds it.
// - While limiting, acceleration time acts as a locked-rotor timeout.
// - Full voltage missing at acceleration timeout disables motor, ramp-timeout error.
// - Ramped stop drops output at once to the deceleration step voltage.
// - Step voltage applies only when a deceleration time is set.
// - Ramp down from step to thyristor cutoff, about 30 percent, over decel time.
// - During acceleration hold current at or below the start current limit.
// - No current limiting while the kick pulse function is enabled.
// - Current above overcurrent level for overcurrent time trips with high-current error.
// - Over and undercurrent protections armed only at full voltage after start.
// - Current below undercurrent level for undercurrent time trips with low-current error.
// - Overcurrent time is off or 1 to 20 seconds.
// - Undercurrent time is off or 1 to 30 seconds.
// - One of five rated currents is the reference for current percentages.
// - Load power is computed from the selected rated line voltage.
// - Phase check on demands R-S-T order; off accepts any order.
// - Phase order sampled once at first power-stage activation after reset.
// - Jog input ramps up to jog voltage; opening ramps down if decel set.
// - Jog limited to acceleration time, then firing stops with ramp-timeout error.
// - Jog voltage is 25 to 50 percent, default 25.
// - Acceleration starts at initial voltage, 25 to 90 percent, default 30.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSR_CLK_KHZ      125000
`define SSR_TICK_MS      10
`define SSR_TICKS_PER_S  15'h64
// ----------------------------------------------------------------------
// Voltage levels and setting ranges, percent or seconds
// ----------------------------------------------------------------------
`define SSR_VOLT_FULL    8'h64
`define SSR_VOLT_CUTOFF  8'h1e
`define SSR_INIT_MIN     8'h19
`define SSR_INIT_MAX     8'h5a
`define SSR_INIT_DEF     8'h1e
`define SSR_ACC_MIN      8'h01
`define SSR_ACC_MAX      8'hf0
`define SSR_ACC_DEF      8'h14
`define SSR_STEP_MIN     8'h28
`define SSR_STEP_MAX     8'h64
`define SSR_DEC_MIN      8'h02
`define SSR_DEC_MAX      8'hf0
`define SSR_LIM_MIN      9'h096
`define SSR_LIM_MAX      9'h1f4
`define SSR_OC_MIN       8'h20
`define SSR_OC_MAX       8'hc8
`define SSR_OC_DEF       8'h78
`define SSR_UC_DEF       8'h46
`define SSR_OCT_MAX      8'h14
`define SSR_UCT_MAX      8'h1e
`define SSR_JOG_MIN      8'h19
`define SSR_JOG_MAX      8'h32
`define SSR_JOG_FUNC     3'h4
`define SSR_PCT_SCALE    18'h00064
`define SSR_SQRT3_Q8     30'h000001bb
// ----------------------------------------------------------------------
// Rated current table, amperes, and rated voltage table, volts
// ----------------------------------------------------------------------
`define SSR_I0 7'h10
`define SSR_I1 7'h1e
`define SSR_I2 7'h2d
`define SSR_I3 7'h3c
`define SSR_I4 7'h55
`define SSR_V0 10'h0dc
`define SSR_V1 10'h0e6
`define SSR_V2 10'h0f0
`define SSR_V3 10'h17c
`define SSR_V4 10'h190
`define SSR_V5 10'h19f
`define SSR_V6 10'h1b8
`define SSR_V7 10'h1cc
`define SSR_V8 10'h1e0
`define SSR_V9 10'h20d
`define SSR_V10 10'h23f
`define SSR_VSEL_DEF 4'h3
`endif

// *** rtl/ssr_pkg.sv ***
// Types shared by the soft-start ramp and protection block.
// Assumes nothing of its surroundings.
package ssr_pkg;
  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ACCEL = 3'b001,
    ST_RUN   = 3'b010,
    ST_DECEL = 3'b011,
    ST_JOG   = 3'b100,
    ST_JOGDN = 3'b101,
    ST_FAULT = 3'b110
  } ssr_state_t;
  // ----------------------------------------------------------------------
  // Reported error codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ERR_NONE         = 2'b00,
    ERR_RAMP_TIMEOUT = 2'b01,
    ERR_LOW_CURRENT  = 2'b10,
    ERR_HIGH_CURRENT = 2'b11
  } ssr_err_t;
endpackage

// *** rtl/ssr_ramp_dda.sv ***
// Linear ramp stepper: moves a level one unit toward a target at an even rate.
// Assumes the caller holds target, delta and span steady between loads.
`timescale 1ns/100ps
`include "ssr_defines.svh"
module ssr_ramp_dda #(
  parameter int VW = 8,
  parameter int SW = 15
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [VW-1:0] load_val,
  input  wire logic          step_en,
  input  wire logic [VW-1:0] target,
  input  wire logic [VW-1:0] delta,
  input  wire logic [SW-1:0] span,
  output logic      [VW-1:0] level_q
);
  logic [SW:0] acc_q;
  logic [SW:0] acc_sum;

  // ----------------------------------------------------------------------
  // Error accumulator gives delta unit steps over span ticks
  // ----------------------------------------------------------------------
  assign acc_sum = acc_q + (SW+1)'(delta);

  // Level and accumulator update
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= '0;
      acc_q   <= '0;
    end else if (load) begin
      level_q <= load_val;
      acc_q   <= '0;
    end else if (step_en && level_q != target) begin
      if (acc_sum >= (SW+1)'(span)) begin
        acc_q <= acc_sum - (SW+1)'(span);
        if (level_q < target) begin
          level_q <= level_q + VW'(1);
        end else begin
          level_q <= level_q - VW'(1);
        end
      end else begin
        acc_q <= acc_sum;
      end
    end
  end
endmodule

// *** rtl/ssr_ramp_protect.sv ***
// Soft-start voltage sequencer with current limit, jog and running protections.
// Assumes settings held steady by the keypad logic and synchronous inputs.
`timescale 1ns/100ps
`include "ssr_defines.svh"
module ssr_ramp_protect #(
  parameter int TICK_CYCLES = `SSR_TICK_MS * `SSR_CLK_KHZ
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                start_cmd,
  input  wire logic                stop_cmd,
  input  wire logic                fault_clear,
  input  wire logic                jog_input,
  input  wire logic                phase_rst_ok,
  input  wire logic [9:0]          load_current_a,
  input  wire logic [7:0]          initial_voltage_level,
  input  wire logic [7:0]          accel_ramp_time,
  input  wire logic [7:0]          decel_voltage_step,
  input  wire logic [7:0]          decel_ramp_time,
  input  wire logic [8:0]          start_current_limit,
  input  wire logic [7:0]          overcurrent_level,
  input  wire logic [7:0]          overcurrent_time,
  input  wire logic [7:0]          undercurrent_level,
  input  wire logic [7:0]          undercurrent_time,
  input  wire logic [2:0]          rated_device_current,
  input  wire logic [3:0]          rated_line_voltage,
  input  wire logic                phase_order_check,
  input  wire logic [7:0]          jog_voltage_level,
  input  wire logic [7:0]          kick_pulse_time,
  input  wire logic [2:0]          input_four_function,
  output logic      [7:0]          volt_ref_q,
  output logic                     firing_en_q,
  output logic                     at_full_q,
  output logic                     cur_limiting_q,
  output ssr_pkg::ssr_err_t        err_code_q,
  output logic                     phase_fault_q,
  output logic      [19:0]         load_power_va_q,
  output ssr_pkg::ssr_state_t      state_q
);
  import ssr_pkg::*;

  ssr_state_t  state_d;
  ssr_err_t    err_d;
  logic [20:0] tick_cnt_q;
  logic        tick;
  logic [14:0] elapsed_q;
  logic [14:0] oc_cnt_q;
  logic [14:0] uc_cnt_q;
  logic [7:0]  from_q;
  logic        phase_seen_q;
  logic        phase_ok_q;
  logic [7:0]  init_v, acc_t, step_v, dec_t, jog_v;
  logic [14:0] acc_span, dec_span;
  logic [6:0]  rated_a;
  logic        decel_on, jog_mode, lim_hold, phase_block, attempt;
  logic        oc_trip, uc_trip;
  logic        load;
  logic [7:0]  load_val, target, delta;
  logic [14:0] span;
  logic        step_en;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [14:0] to_ticks(input logic [7:0] sec);
    return 15'(15'(sec) * `SSR_TICKS_PER_S);
  endfunction

  // Current at or above pct percent of the rated device current
  function automatic logic cur_ge(input logic [9:0] cur, input logic [8:0] pct,
                                  input logic [6:0] rated);
    return (18'(cur) * `SSR_PCT_SCALE) >= (18'(pct) * 18'(rated));
  endfunction

  function automatic logic [6:0] rated_amps(input logic [2:0] sel);
    case (sel)
      3'h0:    return `SSR_I0;
      3'h1:    return `SSR_I1;
      3'h2:    return `SSR_I2;
      3'h3:    return `SSR_I3;
      default: return `SSR_I4;
    endcase
  endfunction

  function automatic logic [9:0] rated_volts(input logic [3:0] sel);
    case (sel)
      4'h0:    return `SSR_V0;
      4'h1:    return `SSR_V1;
      4'h2:    return `SSR_V2;
      4'h3:    return `SSR_V3;
      4'h4:    return `SSR_V4;
      4'h5:    return `SSR_V5;
      4'h6:    return `SSR_V6;
      4'h7:    return `SSR_V7;
      4'h8:    return `SSR_V8;
      4'h9:    return `SSR_V9;
      4'ha:    return `SSR_V10;
      default: return `SSR_V3; // Unlisted codes read as the 380 V default
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Settings brought into range
  // ----------------------------------------------------------------------
  assign init_v   = clamp8(initial_voltage_level, `SSR_INIT_MIN, `SSR_INIT_MAX);
  assign acc_t    = clamp8(accel_ramp_time, `SSR_ACC_MIN, `SSR_ACC_MAX);
  assign step_v   = clamp8(decel_voltage_step, `SSR_STEP_MIN, `SSR_STEP_MAX);
  assign dec_t    = clamp8(decel_ramp_time, `SSR_DEC_MIN, `SSR_DEC_MAX);
  assign jog_v    = clamp8(jog_voltage_level, `SSR_JOG_MIN, `SSR_JOG_MAX);
  assign acc_span = to_ticks(acc_t);
  assign dec_span = to_ticks(dec_t);
  assign decel_on = decel_ramp_time != 8'h00;
  assign jog_mode = input_four_function == `SSR_JOG_FUNC;
  assign rated_a  = rated_device_current > 3'h4 ? `SSR_I4 : rated_amps(rated_device_current);

  // ----------------------------------------------------------------------
  // Ten millisecond time base
  // ----------------------------------------------------------------------
  assign tick = tick_cnt_q == 21'(TICK_CYCLES - 1);

  // Free running divider
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 21'h1;
    end
  end

  // Time spent in the current state, saturating
  always_ff @(posedge clk) begin
    if (rst || state_d != state_q) begin
      elapsed_q <= '0;
    end else if (tick && elapsed_q != 15'h7fff) begin
      elapsed_q <= elapsed_q + 15'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Start current limit, disabled by the kick pulse
  // ----------------------------------------------------------------------
  assign lim_hold = state_q == ST_ACCEL && start_current_limit != 9'h000
                    && kick_pulse_time == 8'h00
                    && cur_ge(load_current_a, start_current_limit, rated_a);

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_limiting_q <= 1'b0;
    end else begin
      cur_limiting_q <= lim_hold;
    end
  end

  // ----------------------------------------------------------------------
  // Running over and undercurrent timers
  // ----------------------------------------------------------------------
  assign oc_trip = overcurrent_time != 8'h00
                   && oc_cnt_q >= to_ticks(clamp8(overcurrent_time, 8'h01, `SSR_OCT_MAX));
  assign uc_trip = undercurrent_time != 8'h00
                   && uc_cnt_q >= to_ticks(clamp8(undercurrent_time, 8'h01, `SSR_UCT_MAX));

  // Counting only while at full voltage in the run state
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_RUN) begin
      oc_cnt_q <= '0;
      uc_cnt_q <= '0;
    end else if (tick) begin
      if (!cur_ge(load_current_a, 9'(clamp8(overcurrent_level, `SSR_OC_MIN, `SSR_OC_MAX)) + 9'h1,
                  rated_a)) begin
        oc_cnt_q <= '0;
      end else if (!oc_trip) begin
        oc_cnt_q <= oc_cnt_q + 15'h1;
      end
      if (cur_ge(load_current_a, 9'(undercurrent_level), rated_a)) begin
        uc_cnt_q <= '0;
      end else if (!uc_trip) begin
        uc_cnt_q <= uc_cnt_q + 15'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase order, caught once at the first activation
  // ----------------------------------------------------------------------
  assign attempt     = state_q == ST_IDLE && (start_cmd || (jog_mode && jog_input));
  assign phase_block = phase_order_check
                       && !(phase_seen_q ? phase_ok_q : phase_rst_ok);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_seen_q  <= 1'b0;
      phase_ok_q    <= 1'b0;
      phase_fault_q <= 1'b0;
    end else begin
      if (attempt && !phase_seen_q) begin
        phase_seen_q <= 1'b1;
        phase_ok_q   <= phase_rst_ok;
      end
      if (attempt && phase_block) begin
        phase_fault_q <= 1'b1;
      end else if (fault_clear) begin
        phase_fault_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    err_d   = err_code_q;
    case (state_q)
      ST_IDLE: begin
        if (!phase_block && start_cmd) begin
          state_d = ST_ACCEL;
        end else if (!phase_block && jog_mode && jog_input) begin
          state_d = ST_JOG;
        end
      end
      ST_ACCEL: begin
        if (volt_ref_q == `SSR_VOLT_FULL) begin
          state_d = ST_RUN;
        end else if (elapsed_q >= acc_span) begin
          state_d = ST_FAULT;
          err_d   = ERR_RAMP_TIMEOUT;
        end else if (stop_cmd) begin
          state_d = decel_on ? ST_DECEL : ST_IDLE;
        end
      end
      ST_RUN: begin
        if (oc_trip) begin
          state_d = ST_FAULT;
          err_d   = ERR_HIGH_CURRENT;
        end else if (uc_trip) begin
          state_d = ST_FAULT;
          err_d   = ERR_LOW_CURRENT;
        end else if (stop_cmd) begin
          state_d = decel_on ? ST_DECEL : ST_IDLE;
        end
      end
      ST_DECEL: begin
        if (volt_ref_q <= `SSR_VOLT_CUTOFF) begin
          state_d = ST_IDLE;
        end
      end
      ST_JOG: begin
        if (elapsed_q >= acc_span) begin
          state_d = ST_FAULT;
          err_d   = ERR_RAMP_TIMEOUT;
        end else if (!jog_input) begin
          state_d = decel_on ? ST_JOGDN : ST_IDLE;
        end
      end
      ST_JOGDN: begin
        if (volt_ref_q <= `SSR_VOLT_CUTOFF) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (fault_clear) begin
          state_d = ST_IDLE;
          err_d   = ERR_NONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State, error and firing registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      err_code_q  <= ERR_NONE;
      firing_en_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      err_code_q  <= err_d;
      firing_en_q <= state_d != ST_IDLE && state_d != ST_FAULT;
    end
  end

  // ----------------------------------------------------------------------
  // Ramp control
  // ----------------------------------------------------------------------
  assign load = state_d != state_q;

  // Level loaded on entry to each state
  always_comb begin
    case (state_d)
      ST_ACCEL: load_val = init_v;
      ST_DECEL: load_val = step_v < volt_ref_q ? step_v : volt_ref_q;
      ST_JOG:   load_val = init_v < jog_v ? init_v : jog_v;
      ST_JOGDN: load_val = volt_ref_q;
      ST_RUN:   load_val = `SSR_VOLT_FULL;
      default:  load_val = 8'h00;
    endcase
  end

  always_comb begin
    case (state_q)
      ST_ACCEL: target = `SSR_VOLT_FULL;
      ST_JOG:   target = jog_v;
      default:  target = `SSR_VOLT_CUTOFF;
    endcase
  end

  assign span    = (state_q == ST_ACCEL || state_q == ST_JOG) ? acc_span : dec_span;
  assign delta   = from_q > target ? from_q - target : target - from_q;
  assign step_en = tick && !lim_hold && state_q != ST_RUN && firing_en_q;

  // Start point of the present ramp
  always_ff @(posedge clk) begin
    if (rst) begin
      from_q <= 8'h00;
    end else if (load) begin
      from_q <= load_val;
    end
  end

  ssr_ramp_dda #(
    .VW (8),
    .SW (15)
  ) u_ramp (
    .clk      (clk),
    .rst      (rst),
    .load     (load),
    .load_val (load_val),
    .step_en  (step_en),
    .target   (target),
    .delta    (delta),
    .span     (span),
    .level_q  (volt_ref_q)
  );

  // ----------------------------------------------------------------------
  // Full voltage flag and apparent power
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      at_full_q       <= 1'b0;
      load_power_va_q <= '0;
    end else begin
      at_full_q       <= state_d == ST_RUN;
      load_power_va_q <= 20'((30'(rated_volts(rated_line_voltage)) * 30'(load_current_a)
                         * `SSR_SQRT3_Q8) >> 8);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ramp_stop;
    stop_cmd && decel_on && ((state_q == ST_RUN && !oc_trip && !uc_trip)
      || (state_q == ST_ACCEL && volt_ref_q != `SSR_VOLT_FULL && elapsed_q < acc_span));
  endsequence
  sequence s_in_decel;
    state_q == ST_DECEL && volt_ref_q <= `SSR_VOLT_CUTOFF;
  endsequence

  accel_rising_a: assert property (state_q == ST_ACCEL && $past(state_q) == ST_ACCEL
    |-> volt_ref_q >= $past(volt_ref_q)) else $error("ramp fell during acceleration");
  limit_hold_a: assert property (lim_hold && !load |=> $stable(volt_ref_q))
    else $error("ramp moved while current limited");
  ramp_timeout_a: assert property (state_q == ST_ACCEL && volt_ref_q != `SSR_VOLT_FULL
    && elapsed_q >= acc_span |=> state_q == ST_FAULT && err_code_q == ERR_RAMP_TIMEOUT)
    else $error("missing ramp timeout trip");
  decel_step_a: assert property (s_ramp_stop |=> state_q == ST_DECEL
    && volt_ref_q <= step_v) else $error("decel step not applied");
  coast_stop_a: assert property (state_q == ST_RUN && stop_cmd && !decel_on
    && !oc_trip && !uc_trip |=> !firing_en_q) else $error("coast stop kept firing");
  cutoff_end_a: assert property (s_in_decel |=> state_q == ST_IDLE && !firing_en_q)
    else $error("decel did not end at cutoff");
  arm_run_a: assert property (state_q != ST_RUN |=> oc_cnt_q == 15'h0
    && uc_cnt_q == 15'h0) else $error("protection counted outside run");
  oc_trip_a: assert property (state_q == ST_RUN && oc_trip |=> err_code_q == ERR_HIGH_CURRENT)
    else $error("overcurrent trip lost");
  phase_stop_a: assert property (attempt && phase_block |=> !firing_en_q && phase_fault_q)
    else $error("wrong phase order started");
  jog_timeout_a: assert property (state_q == ST_JOG && elapsed_q >= acc_span
    |=> !firing_en_q && err_code_q == ERR_RAMP_TIMEOUT) else $error("jog not time limited");
endmodule
